// [hdl/mwlc_top.sv]
// Purpose: mouse wake select, port swap, double click, spinup and indicator control
// Assumes: SYS_RST is the battery reset; other resets arrive as pins
// Notes: pins are open drain; output enables are active low
// Functional notes
// - test register bits 2-4,6,7 read only, zero on battery reset
// - six-bit double click interval, steps of 0.0859375 s
// - two clicks must fall within the interval to count as double
// - double click register bit 6 always reads zero
// - bit 7 set skips spinup delay, clear waits two seconds
// - interval bits writable only while the wake lock is clear
// - double click register resets to 0x0C on battery reset
// - select codes 0-3 choose any event, left, right or any click
// - codes 5 and 6 wake on left or right double click
// - wake control bit 5 always reads zero
// - swap bit exchanges keyboard and mouse ports
// - lock bit cleared by every reset
// - other wake control bits clear only on battery reset
// - lock set makes wake control read only until reset
// - indicator modes off, on, and 1 Hz half duty blink
// - mode 2 blinks 0.5 s on 1.5 s off; standby reset clears mode
`timescale 1ns/1ns
module mwlc_top
  import mwlc_pkg::*;
#(
  parameter int TICK_CYCLES = MWLC_TICK_CYCLES
) (
  input wire logic CLOCK,
  input wire logic SYS_RST,
  input wire logic STBY_POR,
  input wire logic MAIN_POR,
  input wire logic PCI_RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic KBD_CLK_IN,
  input wire logic KBD_DAT_IN,
  input wire logic MSE_CLK_IN,
  input wire logic MSE_DAT_IN,
  output logic KBD_CLK_OUT,
  output logic KBD_DAT_OUT,
  output logic MSE_CLK_OUT,
  output logic MSE_DAT_OUT,
  output logic KBD_CLK_OE_N,
  output logic KBD_DAT_OE_N,
  output logic MSE_CLK_OE_N,
  output logic MSE_DAT_OE_N,
  input wire logic CTL_KCLK_LOW,
  input wire logic CTL_KDAT_LOW,
  input wire logic CTL_MCLK_LOW,
  input wire logic CTL_MDAT_LOW,
  output logic CTL_KCLK,
  output logic CTL_KDAT,
  output logic CTL_MCLK,
  output logic CTL_MDAT,
  output logic PME_WAKE,
  output logic SPINUP_READY,
  output logic INDICATOR_ONE
);
  // ************************************************************
  // synchronisers and slow tick
  // ************************************************************
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic tick;
  logic stby_s, main_s, pci_s;
  logic kclk_s, kdat_s, mclk_s, mdat_s;

  initial begin
    if (TICK_CYCLES < 2) begin
      $error("tick cycles must be at least two");
    end
  end

  // two flops on every pin input; stage one feeds stage two only
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync1_reg <= MWLC_SYNC_RST; // link lines idle high, resets low
      sync2_reg <= MWLC_SYNC_RST;
    end else begin
      sync1_reg <= {STBY_POR, MAIN_POR, PCI_RST, KBD_CLK_IN, KBD_DAT_IN,
                    MSE_CLK_IN, MSE_DAT_IN};
      sync2_reg <= sync1_reg;
    end
  end
  assign {stby_s, main_s, pci_s, kclk_s, kdat_s, mclk_s, mdat_s} = sync2_reg;

  mwlc_tick_div #(.CYCLES(TICK_CYCLES)) u_tick (
    .clk(CLOCK),
    .rst(SYS_RST),
    .tick(tick)
  );

  // ************************************************************
  // register file
  // ************************************************************
  logic [7:0] test_reg;
  logic [5:0] dci_reg;
  logic spin_skip_reg;
  logic [6:0] mwc_reg;
  logic lock_reg;
  logic [1:0] led_mode_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [2:0] sel;
  logic swap;

  assign sel = mwc_reg[MWLC_SEL_LSB +: 3];
  assign swap = mwc_reg[MWLC_SWAP_BIT];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // test register keeps only its factory bits, battery reset only
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      test_reg <= MWLC_TEST_RST;
    end else if (WR && hit(ADDR, MWLC_OFF_TEST)) begin
      test_reg <= WDATA & MWLC_TEST_WMASK;
    end
  end

  // interval field, locked by the wake lock; spinup bit always writable
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      dci_reg <= MWLC_DCI_RST;
      spin_skip_reg <= MWLC_SPIN_RST;
    end else if (WR && hit(ADDR, MWLC_OFF_DCI)) begin
      if (!lock_reg) begin
        dci_reg <= WDATA[5:0];
      end
      spin_skip_reg <= WDATA[MWLC_SPIN_BIT];
    end
  end

  // wake control body survives every reset but the battery one
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mwc_reg <= MWLC_MWC_RST;
    end else if (WR && hit(ADDR, MWLC_OFF_MWC) && !lock_reg) begin
      mwc_reg <= {WDATA[6], 1'b0, WDATA[4:0]};
    end
  end

  // lock is set by software and cleared only by a reset
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lock_reg <= 1'b0;
    end else if (stby_s || main_s || pci_s) begin
      lock_reg <= 1'b0;
    end else if (WR && hit(ADDR, MWLC_OFF_MWC) && !lock_reg) begin
      lock_reg <= WDATA[MWLC_LOCK_BIT];
    end
  end

  // indicator mode, cleared by battery and standby resets
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      led_mode_reg <= MWLC_LED_RST;
    end else if (stby_s) begin
      led_mode_reg <= MWLC_LED_RST;
    end else if (WR && hit(ADDR, MWLC_OFF_LED)) begin
      led_mode_reg <= WDATA[1:0];
    end
  end

  // read mux; reserved bits and unmapped offsets read zero
  always_comb begin
    rdata_next = 8'h00;
    if (hit(ADDR, MWLC_OFF_TEST)) begin
      rdata_next = test_reg;
    end else if (hit(ADDR, MWLC_OFF_DCI)) begin
      rdata_next = {spin_skip_reg, 1'b0, dci_reg};
    end else if (hit(ADDR, MWLC_OFF_MWC)) begin
      rdata_next = {lock_reg, mwc_reg[6], 1'b0, mwc_reg[4:0]};
    end else if (hit(ADDR, MWLC_OFF_LED)) begin
      rdata_next = {6'h00, led_mode_reg};
    end
  end

  // read data stand for the one cycle after the strobe
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_reg <= 8'h00;
    end else if (RD) begin
      rdata_reg <= rdata_next;
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign RDATA = rdata_reg;

  // ************************************************************
  // port swap routing
  // ************************************************************
  logic [3:0] ctl_in_reg;
  logic [3:0] oe_n_reg;
  logic [3:0] pin_out_reg;
  logic mouse_clk, mouse_dat;

  assign mouse_clk = swap ? kclk_s : mclk_s;
  assign mouse_dat = swap ? kdat_s : mdat_s;

  // controller sees the ports exchanged when swapped
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctl_in_reg <= 4'hF;
      oe_n_reg <= 4'hF;
      pin_out_reg <= 4'h0;
    end else if (swap) begin
      ctl_in_reg <= {mclk_s, mdat_s, kclk_s, kdat_s};
      oe_n_reg <= {~CTL_MCLK_LOW, ~CTL_MDAT_LOW, ~CTL_KCLK_LOW, ~CTL_KDAT_LOW};
      pin_out_reg <= 4'h0;
    end else begin
      ctl_in_reg <= {kclk_s, kdat_s, mclk_s, mdat_s};
      oe_n_reg <= {~CTL_KCLK_LOW, ~CTL_KDAT_LOW, ~CTL_MCLK_LOW, ~CTL_MDAT_LOW};
      pin_out_reg <= 4'h0;
    end
  end
  assign {CTL_KCLK, CTL_KDAT, CTL_MCLK, CTL_MDAT} = ctl_in_reg;
  assign {KBD_CLK_OE_N, KBD_DAT_OE_N, MSE_CLK_OE_N, MSE_DAT_OE_N} = oe_n_reg;
  assign {KBD_CLK_OUT, KBD_DAT_OUT, MSE_CLK_OUT, MSE_DAT_OUT} = pin_out_reg;

  // ************************************************************
  // mouse packet decoder
  // ************************************************************
  logic mclk_prev_reg;
  logic [3:0] bit_cnt_reg;
  logic [10:0] shift_reg;
  logic [1:0] idle_reg;
  logic [1:0] byte_idx_reg;
  logic [2:0] btn_reg;
  logic [2:0] btn_new_reg;
  logic moved_reg;
  logic pkt_done_reg;
  logic fall;
  logic [7:0] rx_byte;

  assign fall = mclk_prev_reg && !mouse_clk;
  assign rx_byte = shift_reg[9:2];

  // frames are sampled on falling mouse clock; idle gaps resync
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mclk_prev_reg <= 1'b1;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 11'h000;
      idle_reg <= 2'h0;
      byte_idx_reg <= 2'h0;
      btn_new_reg <= 3'h0;
      moved_reg <= 1'b0;
      pkt_done_reg <= 1'b0;
    end else begin
      mclk_prev_reg <= mouse_clk;
      pkt_done_reg <= 1'b0;
      if (fall) begin
        idle_reg <= 2'h0;
        shift_reg <= {mouse_dat, shift_reg[10:1]};
        if (bit_cnt_reg == MWLC_FRAME_BITS) begin
          bit_cnt_reg <= 4'h0;
          if (byte_idx_reg == 2'h0) begin
            if (rx_byte[3]) begin
              btn_new_reg <= rx_byte[2:0];
              moved_reg <= 1'b0;
              byte_idx_reg <= 2'h1;
            end
          end else begin
            if (rx_byte != 8'h00) begin
              moved_reg <= 1'b1;
            end
            if (byte_idx_reg == 2'h2) begin
              byte_idx_reg <= 2'h0;
              pkt_done_reg <= 1'b1;
            end else begin
              byte_idx_reg <= 2'h2;
            end
          end
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 1'b1;
        end
      end else if (tick) begin
        if (idle_reg == MWLC_IDLE_TICKS) begin
          bit_cnt_reg <= 4'h0;
          byte_idx_reg <= 2'h0;
        end else begin
          idle_reg <= idle_reg + 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // wake event selection and double click window
  // ************************************************************
  logic [2:0] press;
  logic [9:0] win_reg;
  logic [9:0] win_load;
  mwlc_dc_t dc_state_reg;
  logic wake_reg;
  logic click_sel;
  logic dbl_mode;

  assign press = btn_new_reg & ~btn_reg;
  assign win_load = 10'(dci_reg * MWLC_STEP_TICKS);
  assign dbl_mode = (sel == MWLC_SEL_DBL_L) || (sel == MWLC_SEL_DBL_R);
  assign click_sel = (sel == MWLC_SEL_DBL_L) ? press[0] : press[1];

  // remembered button state between packets
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      btn_reg <= 3'h0;
    end else if (pkt_done_reg) begin
      btn_reg <= btn_new_reg;
    end
  end

  // single events and double-click tracking
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wake_reg <= 1'b0;
      win_reg <= 10'h000;
      dc_state_reg <= MWLC_DC_IDLE;
    end else begin
      wake_reg <= 1'b0;
      if (tick && win_reg != 10'h000) begin
        win_reg <= win_reg - 1'b1;
      end
      if (!dbl_mode || (dc_state_reg == MWLC_DC_ARMED && win_reg == 10'h000) ||
          (WR && hit(ADDR, MWLC_OFF_MWC) && !lock_reg)) begin
        dc_state_reg <= MWLC_DC_IDLE;
      end
      if (pkt_done_reg) begin
        case (sel)
          MWLC_SEL_ANY: wake_reg <= (press != 3'h0) || moved_reg;
          MWLC_SEL_LEFT: wake_reg <= press[0];
          MWLC_SEL_RIGHT: wake_reg <= press[1];
          MWLC_SEL_ONE: wake_reg <= (press != 3'h0);
          MWLC_SEL_DBL_L, MWLC_SEL_DBL_R: begin
            if (click_sel) begin
              case (dc_state_reg)
                MWLC_DC_IDLE: begin
                  win_reg <= win_load;
                  dc_state_reg <= (win_load != 10'h000) ? MWLC_DC_ARMED : MWLC_DC_IDLE;
                end
                MWLC_DC_ARMED: begin
                  wake_reg <= 1'b1;
                  win_reg <= 10'h000;
                  dc_state_reg <= MWLC_DC_IDLE;
                end
                default: dc_state_reg <= MWLC_DC_IDLE;
              endcase
            end
          end
          default: wake_reg <= 1'b0;
        endcase
      end
    end
  end
  assign PME_WAKE = wake_reg;

  // ************************************************************
  // spinup delay and indicator
  // ************************************************************
  logic [8:0] spin_cnt_reg;
  logic spin_done_reg;
  logic [7:0] phase_reg;
  logic led_reg;

  // standby reset restarts the spinup wait
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      spin_cnt_reg <= 9'h000;
      spin_done_reg <= 1'b0;
    end else if (stby_s) begin
      spin_cnt_reg <= 9'h000;
      spin_done_reg <= 1'b0;
    end else if (!spin_done_reg) begin
      if (spin_skip_reg || spin_cnt_reg == MWLC_SPIN_TICKS) begin
        spin_done_reg <= 1'b1;
      end else if (tick) begin
        spin_cnt_reg <= spin_cnt_reg + 1'b1;
      end
    end
  end
  assign SPINUP_READY = spin_done_reg;

  // phase counts ticks over a two-second period
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      phase_reg <= 8'h00;
    end else if (tick) begin
      phase_reg <= phase_reg + 1'b1;
    end
  end

  // indicator drive from mode and phase
  always_ff @(posedge CLOCK or posedge SYS_RST) begin
    if (SYS_RST) begin
      led_reg <= 1'b0;
    end else begin
      case (led_mode_reg)
        MWLC_LED_OFF: led_reg <= 1'b0;
        MWLC_LED_1HZ: led_reg <= !phase_reg[6];
        MWLC_LED_HALF: led_reg <= (phase_reg[7:6] == 2'h0);
        MWLC_LED_ON: led_reg <= 1'b1;
        default: led_reg <= 1'b0;
      endcase
    end
  end
  assign INDICATOR_ONE = led_reg;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  a_test_reserved: assert property (
    RD && ADDR == MWLC_OFF_TEST |=> RDATA[4:2] == 3'h0 && RDATA[7:6] == 2'h0)
    else $error("test register reserved bits not zero");
  a_dci_bit6_zero: assert property (
    RD && ADDR == MWLC_OFF_DCI |=> !RDATA[6])
    else $error("interval bit 6 not zero");
  a_mwc_bit5_zero: assert property (
    RD && ADDR == MWLC_OFF_MWC |=> !RDATA[5])
    else $error("wake control bit 5 not zero");
  a_lock_holds_mwc: assert property (
    lock_reg && !stby_s && !main_s && !pci_s |=> lock_reg && $stable(mwc_reg))
    else $error("locked wake control changed");
  a_dci_locked: assert property (
    lock_reg && WR && ADDR == MWLC_OFF_DCI |=> $stable(dci_reg))
    else $error("interval written while locked");
  a_lock_reset: assert property (
    pci_s || main_s || stby_s |=> !lock_reg)
    else $error("lock survived reset");
  a_led_steady: assert property (
    led_mode_reg == MWLC_LED_ON [*2] |-> INDICATOR_ONE)
    else $error("indicator not on in on mode");
  a_led_quarter: assert property (
    led_mode_reg == MWLC_LED_HALF && $past(led_mode_reg) == MWLC_LED_HALF
    |-> INDICATOR_ONE == ($past(phase_reg[7:6]) == 2'h0))
    else $error("quarter duty blink wrong");
  a_spin_skip: assert property (
    $fell(stby_s) && spin_skip_reg |-> ##[1:2] SPINUP_READY)
    else $error("spinup not skipped");
  a_swap_route: assert property (
    swap |=> CTL_MCLK == $past(kclk_s) && CTL_KCLK == $past(mclk_s))
    else $error("swap routing wrong");

  c_wake: cover property (PME_WAKE);
  c_dbl_wake: cover property (dbl_mode && PME_WAKE);
  c_lock: cover property ($rose(lock_reg));
  c_spin: cover property ($rose(SPINUP_READY) && !spin_skip_reg);
endmodule

// [hdl/mwlc_pkg.sv]
// Purpose: shared constants for the mouse wake and indicator control slice
// Assumes: 25 MHz system clock, 8-bit register port
// Notes: all timing derives from one slow tick of 1/128 second
package mwlc_pkg;
  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] MWLC_OFF_TEST = 8'h5A;
  localparam logic [7:0] MWLC_OFF_DCI = 8'h5B;
  localparam logic [7:0] MWLC_OFF_MWC = 8'h5C;
  localparam logic [7:0] MWLC_OFF_LED = 8'h5D;
  // ************************************************************
  // reset values and field layout
  // ************************************************************
  localparam logic [7:0] MWLC_TEST_RST = 8'h00;
  localparam logic [7:0] MWLC_TEST_WMASK = 8'h23;
  localparam logic [5:0] MWLC_DCI_RST = 6'h0C;
  localparam logic MWLC_SPIN_RST = 1'b0;
  localparam logic [6:0] MWLC_MWC_RST = 7'h00;
  localparam logic [1:0] MWLC_LED_RST = 2'h0;
  localparam logic [6:0] MWLC_SYNC_RST = 7'h0F;
  localparam int MWLC_SEL_LSB = 2;
  localparam int MWLC_SWAP_BIT = 6;
  localparam int MWLC_LOCK_BIT = 7;
  localparam int MWLC_SPIN_BIT = 7;
  // ************************************************************
  // wake select codes and indicator modes
  // ************************************************************
  localparam logic [2:0] MWLC_SEL_ANY = 3'h0;
  localparam logic [2:0] MWLC_SEL_LEFT = 3'h1;
  localparam logic [2:0] MWLC_SEL_RIGHT = 3'h2;
  localparam logic [2:0] MWLC_SEL_ONE = 3'h3;
  localparam logic [2:0] MWLC_SEL_DBL_L = 3'h5;
  localparam logic [2:0] MWLC_SEL_DBL_R = 3'h6;
  localparam logic [1:0] MWLC_LED_OFF = 2'h0;
  localparam logic [1:0] MWLC_LED_1HZ = 2'h1;
  localparam logic [1:0] MWLC_LED_HALF = 2'h2;
  localparam logic [1:0] MWLC_LED_ON = 2'h3;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int MWLC_CLK_NS = 40;
  localparam int MWLC_TICK_NS = 7812500;
  localparam int MWLC_TICK_CYCLES = MWLC_TICK_NS / MWLC_CLK_NS;
  localparam int MWLC_STEP_NS = 85937500;
  localparam int MWLC_STEP_TICKS = MWLC_STEP_NS / MWLC_TICK_NS;
  localparam int MWLC_HALF_S_NS = 500000000;
  localparam int MWLC_HALF_TICKS = MWLC_HALF_S_NS / MWLC_TICK_NS;
  localparam int MWLC_SPIN_NS = 2000000000;
  localparam logic [8:0] MWLC_SPIN_TICKS = 9'(MWLC_SPIN_NS / MWLC_TICK_NS);
  localparam logic [1:0] MWLC_IDLE_TICKS = 2'h2;
  localparam logic [3:0] MWLC_FRAME_BITS = 4'hA;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic {MWLC_DC_IDLE, MWLC_DC_ARMED} mwlc_dc_t;
endpackage

// [hdl/mwlc_tick_div.sv]
// Purpose: divides the system clock down to a one-cycle slow tick
// Assumes: CYCLES is at least 2
// Notes: tick_reg is high for one clock every CYCLES clocks
`timescale 1ns/1ns
module mwlc_tick_div #(
  parameter int CYCLES = 195312
) (
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  localparam int CW = $clog2(CYCLES);
  logic [CW-1:0] cnt_reg;
  logic tick_reg;

  initial begin
    if (CYCLES < 2) begin
      $error("tick divider needs at least two cycles");
    end
  end

  // free-running count that wraps at CYCLES
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else if (cnt_reg == CW'(CYCLES - 1)) begin
      cnt_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  assign tick = tick_reg;
endmodule

// [test/mwlc_mouse_model.sv]
// Purpose: behavioural mouse that sends packets on the clock and data lines
// Assumes: open drain lines with pull-ups, so a released line reads high
// Notes: the clock stands high between frames; each bit is three cycles low and four high
`timescale 1ns/1ns
module mwlc_mouse_model (
  input wire logic clk,
  output logic line_clk,
  output logic line_dat
);
  initial begin
    line_clk = 1'b1;
    line_dat = 1'b1;
  end
  // one frame: start, eight bits lsb first, odd parity, stop
  task automatic send_byte(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ~^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      line_dat <= f[i];
      repeat (3) @(posedge clk);
      line_clk <= 1'b0;
      repeat (3) @(posedge clk);
      line_clk <= 1'b1;
    end
    @(posedge clk);
    line_dat <= 1'b1;
  endtask
  // three frames, then an idle gap long enough to end the packet
  task automatic send_packet(input logic [7:0] b0, input logic [7:0] b1);
    send_byte(b0);
    send_byte(b1);
    send_byte(8'h00);
    repeat (20) @(posedge clk);
  endtask
endmodule

// [test/testbench.sv]
// Purpose: self-checking bench for the mouse wake and indicator slice
// Assumes: tick shortened to 4 clocks, so half a second is 256 clocks
// Notes: read results queue up and are checked by a separate watcher
`timescale 1ns/1ns
module testbench;
  import mwlc_pkg::*;
  logic clk, sys_rst, wr, rd, rd_seen, spin, led, pme;
  logic [2:0] por;
  logic [3:0] ctl_low, oe_n, ctl;
  logic [7:0] addr, wdata, rdata;
  logic [7:0] exp_q[$];
  logic mdl_clk, mdl_dat;
  int mismatches, num_checks, wakes, w0, on, cycles;
  int sel_exp[8] = '{3, 1, 1, 2, 0, 0, 0, 0};
  int led_exp[4] = '{0, 512, 256, 1024};
  mwlc_mouse_model mse (.clk(clk), .line_clk(mdl_clk), .line_dat(mdl_dat));
  mwlc_top #(.TICK_CYCLES(4)) dut (
    .CLOCK(clk), .SYS_RST(sys_rst), .STBY_POR(por[2]), .MAIN_POR(por[1]),
    .PCI_RST(por[0]), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .KBD_CLK_IN(oe_n[3]), .KBD_DAT_IN(oe_n[2]),
    .MSE_CLK_IN(mdl_clk & oe_n[1]), .MSE_DAT_IN(mdl_dat & oe_n[0]),
    .KBD_CLK_OUT(), .KBD_DAT_OUT(), .MSE_CLK_OUT(), .MSE_DAT_OUT(),
    .KBD_CLK_OE_N(oe_n[3]), .KBD_DAT_OE_N(oe_n[2]), .MSE_CLK_OE_N(oe_n[1]),
    .MSE_DAT_OE_N(oe_n[0]), .CTL_KCLK_LOW(ctl_low[3]), .CTL_KDAT_LOW(ctl_low[2]),
    .CTL_MCLK_LOW(ctl_low[1]), .CTL_MDAT_LOW(ctl_low[0]), .CTL_KCLK(ctl[3]),
    .CTL_KDAT(ctl[2]), .CTL_MCLK(ctl[1]), .CTL_MDAT(ctl[0]), .PME_WAKE(pme),
    .SPINUP_READY(spin), .INDICATOR_ONE(led)
  );
  // ************************************************************
  // clock, checks and closing
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // watcher: read data stand in the cycle after the strobe
  always @(posedge clk) begin
    rd_seen <= rd;
    if (rd_seen) begin
      chk_reg(rdata, exp_q.pop_front());
    end
    if (pme === 1'b1) begin
      wakes++;
    end
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      finish_test();
    end
  end
  // ************************************************************
  // bus tasks
  // ************************************************************
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic pulse(input logic [2:0] v);
    @(posedge clk);
    por <= v;
    repeat (2) @(posedge clk);
    por <= 3'h0;
    repeat (5) @(posedge clk);
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {sys_rst, wr, rd, por, ctl_low, addr, wdata} = {1'b1, 25'h0};
    void'($urandom(61511));
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd_reg(8'h5A, 8'h00);
    rd_reg(8'h5B, 8'h0C);
    rd_reg(8'h5C, 8'h00);
    wr_reg(8'h70, 8'hA5);
    rd_reg(8'h70, 8'h00);
    wr_reg(8'h5A, 8'hDC);
    rd_reg(8'h5A, 8'h00);
    wr_reg(8'h5B, 8'h7F);
    rd_reg(8'h5B, 8'h3F);
    for (int s = 0; s < 8; s++) begin
      wr_reg(8'h5C, 8'(s << 2));
      w0 = wakes;
      mse.send_packet(8'h09, 8'h00);
      mse.send_packet(8'h0A, 8'h00);
      mse.send_packet(8'h08, 8'(($urandom % 255) + 1));
      chk_cnt(wakes - w0, sel_exp[s]);
    end
    // left double click inside then outside the window
    wr_reg(8'h5C, 8'h14);
    for (int k = 0; k < 2; k++) begin
      w0 = wakes;
      mse.send_packet(8'h09, 8'h00);
      mse.send_packet(8'h08, 8'h00);
      mse.send_packet(8'h09, 8'h00);
      mse.send_packet(8'h08, 8'h00);
      chk_cnt(wakes - w0, 1 - k);
      wr_reg(8'h5B, 8'h02);
    end
    // swapped and normal routing of a controller pull-down
    wr_reg(8'h5C, 8'h40);
    ctl_low <= 4'h8;
    repeat (8) @(posedge clk);
    chk_reg({oe_n, ctl}, 8'hD7);
    wr_reg(8'h5C, 8'h00);
    repeat (8) @(posedge clk);
    chk_reg({oe_n, ctl}, 8'h77);
    ctl_low <= 4'h0;
    for (int m = 0; m < 4; m++) begin
      wr_reg(8'h5D, 8'(m));
      rd_reg(8'h5D, 8'(m));
      on = 0;
      repeat (1024) begin
        @(posedge clk);
        on += (led === 1'b1);
      end
      chk_cnt(on, led_exp[m]);
    end
    pulse(3'h4);
    chk_reg({7'h0, spin}, 8'h00);
    repeat (1100) @(posedge clk);
    chk_reg({7'h0, spin}, 8'h01);
    rd_reg(8'h5D, 8'h00);
    wr_reg(8'h5B, 8'h82);
    pulse(3'h4);
    chk_reg({7'h0, spin}, 8'h01);
    wr_reg(8'h5C, 8'hF8);
    rd_reg(8'h5C, 8'hD8);
    wr_reg(8'h5C, 8'h00);
    wr_reg(8'h5B, 8'h01);
    rd_reg(8'h5C, 8'hD8);
    rd_reg(8'h5B, 8'h02);
    pulse(3'h1);
    rd_reg(8'h5C, 8'h58);
    wr_reg(8'h5B, 8'h81);
    wr_reg(8'h5C, 8'h80);
    rd_reg(8'h5B, 8'h81);
    pulse(3'h2);
    rd_reg(8'h5C, 8'h00);
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule
